// ### core/pecb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pecb_top #(
   parameter logic                       MON_SUPPORTED  = 1'b1, // perf_monitoring_supported
   parameter logic                       CAPS_SUPPORTED = 1'b1, // global per-counter caps flag
   parameter logic [pecb_pkg::NUM_CNT-1:0] OWN_CAPS_FLAGS = 4'h5, // per_counter_caps_flag per counter
   parameter logic [31:0]                CNT_WIDTHS    = 32'h10_20_18_28, // own widths, byte per counter
   parameter logic [127:0]               EV_CAPS       = 128'h3000_00ff_2000_0f0f_1000_00f3_0000_0001
) (
   // clock and reset
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   // event inputs, one pulse per occurrence
   input  wire logic [pecb_pkg::NUM_CNT-1:0] event_hit,
   // axi4-lite write address
   input  wire logic                     s_axi_awvalid,
   output var  logic                     s_axi_awready,
   input  wire logic [11:0]              s_axi_awaddr,
   // axi4-lite write data
   input  wire logic                     s_axi_wvalid,
   output var  logic                     s_axi_wready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   // axi4-lite write response
   output var  logic                     s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   output var  logic [1:0]               s_axi_bresp,
   // axi4-lite read address
   input  wire logic                     s_axi_arvalid,
   output var  logic                     s_axi_arready,
   input  wire logic [11:0]              s_axi_araddr,
   // axi4-lite read data
   output var  logic                     s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   output var  logic [31:0]              s_axi_rdata,
   output var  logic [1:0]               s_axi_rresp,
   // frozen state
   output var  logic                     frozen
);
   localparam int N = pecb_pkg::NUM_CNT;

   // effective width of counter c, per-counter override when its flag and the global caps flag are both set
   function automatic logic [7:0] cnt_width(input int c);
      if (CAPS_SUPPORTED && OWN_CAPS_FLAGS[c])
         return CNT_WIDTHS[c*8 +: 8];        // RQ13
      return pecb_pkg::GLOBAL_WIDTH;         // RQ7
   endfunction

   // mask of valid counter bits for counter c
   function automatic logic [63:0] cnt_mask(input int c);
      logic [7:0] w;
      w = cnt_width(c);
      return (w >= 8'h40) ? 64'hffff_ffff_ffff_ffff : ((64'h1 << w) - 64'h1); // RQ12 RQ14
   endfunction

   // address decode for counter word: returns index, hit, high word select
   function automatic logic [3:0] cnt_decode(input logic [11:0] a);
      logic [11:0] rel;
      logic [11:0] idx;
      rel = a - pecb_pkg::CNT_BASE;
      idx = rel / pecb_pkg::CNT_STRIDE;
      cnt_decode = 4'h0;
      if (MON_SUPPORTED && a >= pecb_pkg::CNT_BASE && idx < 12'(N) && (rel % pecb_pkg::CNT_STRIDE) < 12'h008
          && a[1:0] == 2'h0)
         cnt_decode = {1'b1, rel[2], idx[1:0]};  // RQ11 RQ3
   endfunction

   // counters, enables, freeze
   logic [63:0]  cnt_reg  [N];
   logic [63:0]  cnt_next [N];
   logic [N-1:0] en_reg, en_next;
   logic         frz_reg, frz_next;

   // axi slave state
   pecb_pkg::pecb_state_t st_reg, st_next;
   logic        aw_got_reg, aw_got_next, w_got_reg, w_got_next;
   logic [11:0] awa_reg, awa_next;
   logic [31:0] wd_reg, wd_next;
   logic [3:0]  ws_reg, ws_next;
   logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        aw_rdy_reg, aw_rdy_next, w_rdy_reg, w_rdy_next, ar_rdy_reg, ar_rdy_next;
   logic        bv_reg, bv_next, rv_reg, rv_next;

   // read mux: capability words, counters, control
   function automatic logic [32:0] read_word(input logic [11:0] a);
      logic [3:0]  d;
      logic [31:0] v;
      logic [63:0] cv;
      d = cnt_decode(a);
      read_word = {1'b0, 32'h0};
      if (d[3]) begin
         cv = cnt_reg[d[1:0]] & cnt_mask(int'(d[1:0]));            // RQ12
         read_word = {1'b1, d[2] ? cv[63:32] : cv[31:0]};
      end else if (a == pecb_pkg::EN_OFF) begin
         read_word = {1'b1, {(32-N){1'b0}}, en_reg};
      end else if (a == pecb_pkg::STAT_OFF) begin
         read_word = {1'b1, 28'h0, 1'b0, CAPS_SUPPORTED, MON_SUPPORTED, frz_reg};
      end else begin
         for (int c = 0; c < N; c++) begin
            if (MON_SUPPORTED && CAPS_SUPPORTED) begin                 // RQ1 RQ3
               if (a == pecb_pkg::CFG_BASE + 12'(c) * pecb_pkg::CAP_STRIDE + pecb_pkg::CNTCAP_OFF) begin
                  v = 32'h0;
                  v[pecb_pkg::OWN_CAPS_BIT] = OWN_CAPS_FLAGS[c];
                  v[pecb_pkg::CW_LSB +: 8] = OWN_CAPS_FLAGS[c] ? CNT_WIDTHS[c*8 +: 8] : 8'h0;
                  v[pecb_pkg::GRP_IDX_LSB +: 4] = OWN_CAPS_FLAGS[c] ? 4'h1 : 4'h0;
                  read_word = {1'b1, v};
               end
               if (a == pecb_pkg::CFG_BASE + 12'(c) * pecb_pkg::CAP_STRIDE + pecb_pkg::EVCAP_OFF) begin
                  v = EV_CAPS[c*32 +: 32];                             // RQ2 RQ6
                  if (!OWN_CAPS_FLAGS[c])
                     v[pecb_pkg::GRP_IDX_LSB +: 4] = 4'h0;             // RQ4 RQ5
                  read_word = {1'b1, v};
               end
            end
         end
      end
   endfunction

   // bus slave next state; one write and one read outstanding at most
   always_comb begin
      logic [3:0]  d;
      logic [31:0] m;
      logic [32:0] rw;
      d = 4'h0;
      m = 32'h0;
      rw = 33'h0;
      st_next = st_reg;
      aw_got_next = aw_got_reg;
      w_got_next = w_got_reg;
      awa_next = awa_reg;
      wd_next = wd_reg;
      ws_next = ws_reg;
      bresp_next = bresp_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      en_next = en_reg;
      frz_next = frz_reg;
      for (int c = 0; c < N; c++) begin
         // count when enabled and not frozen, one per event
         if (en_reg[c] && !frz_reg && event_hit[c])                    // RQ9 RQ10 RQ17
            cnt_next[c] = (cnt_reg[c] + 64'h1) & cnt_mask(c);          // RQ7 RQ14
         else
            cnt_next[c] = cnt_reg[c];
      end
      case (st_reg)
         pecb_pkg::PECB_IDLE: begin
            if (s_axi_awvalid && !aw_got_reg) begin
               aw_got_next = 1'b1;
               awa_next = s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_got_reg) begin
               w_got_next = 1'b1;
               wd_next = s_axi_wdata;
               ws_next = s_axi_wstrb;
            end
            if (aw_got_reg && w_got_reg) begin
               // write takes priority over a counted event in the same cycle in the written word; the counter's other word keeps the event
               d = cnt_decode(awa_reg);
               for (int b = 0; b < 4; b++)
                  m[b*8 +: 8] = {8{ws_reg[b]}};
               bresp_next = pecb_pkg::RESP_OKAY;
               // a write to a word that does not read back is refused, except the command word while monitoring is supported
               rw = read_word(awa_reg);
               if (d[3]) begin
                  if (d[2])
                     cnt_next[d[1:0]][63:32] = ((cnt_reg[d[1:0]][63:32] & ~m) | (wd_reg & m));
                  else
                     cnt_next[d[1:0]][31:0] = ((cnt_reg[d[1:0]][31:0] & ~m) | (wd_reg & m));
                  cnt_next[d[1:0]] = cnt_next[d[1:0]] & cnt_mask(int'(d[1:0])); // RQ8 RQ12
               end else if (awa_reg == pecb_pkg::EN_OFF && ws_reg[0]) begin
                  en_next = wd_reg[N-1:0];
               end else if (awa_reg == pecb_pkg::CMD_OFF && MON_SUPPORTED) begin
                  if (ws_reg[0] && wd_reg[7:0] == pecb_pkg::CMD_FREEZE)
                     frz_next = 1'b1;                                  // RQ15
                  else if (ws_reg[0] && wd_reg[7:0] == pecb_pkg::CMD_UNFREEZE)
                     frz_next = 1'b0;                                  // RQ16
               end else if (!rw[32]) begin
                  bresp_next = pecb_pkg::RESP_SLVERR;
               end
               aw_got_next = 1'b0;
               w_got_next = 1'b0;
               st_next = pecb_pkg::PECB_WRESP;
            end else if (s_axi_arvalid) begin
               rw = read_word(s_axi_araddr);
               rdata_next = rw[31:0];
               rresp_next = rw[32] ? pecb_pkg::RESP_OKAY : pecb_pkg::RESP_SLVERR;
               st_next = pecb_pkg::PECB_RDATA;
            end
         end
         pecb_pkg::PECB_WRESP: begin
            if (s_axi_bready)
               st_next = pecb_pkg::PECB_IDLE;
         end
         pecb_pkg::PECB_RDATA: begin
            if (s_axi_rready)
               st_next = pecb_pkg::PECB_IDLE;
         end
         default: st_next = pecb_pkg::PECB_IDLE;
      endcase
      // handshake flags taken from the next state, so every bus output is a flop with no extra latency
      aw_rdy_next = (st_next == pecb_pkg::PECB_IDLE) && !aw_got_next;
      w_rdy_next  = (st_next == pecb_pkg::PECB_IDLE) && !w_got_next;
      ar_rdy_next = (st_next == pecb_pkg::PECB_IDLE) && !(aw_got_next && w_got_next);
      bv_next     = (st_next == pecb_pkg::PECB_WRESP);
      rv_next     = (st_next == pecb_pkg::PECB_RDATA);
   end

   // registered state; all outputs come from these flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg     <= pecb_pkg::PECB_IDLE;
         aw_got_reg <= 1'b0;
         w_got_reg  <= 1'b0;
         awa_reg    <= 12'h0;
         wd_reg     <= 32'h0;
         ws_reg     <= 4'h0;
         bresp_reg  <= 2'h0;
         rresp_reg  <= 2'h0;
         rdata_reg  <= 32'h0;
         en_reg     <= '0;
         frz_reg    <= 1'b0;
         aw_rdy_reg <= 1'b1;
         w_rdy_reg  <= 1'b1;
         ar_rdy_reg <= 1'b1;
         bv_reg     <= 1'b0;
         rv_reg     <= 1'b0;
         for (int c = 0; c < N; c++)
            cnt_reg[c] <= pecb_pkg::CNT_RESET;                         // RQ12
      end else begin
         st_reg     <= st_next;
         aw_got_reg <= aw_got_next;
         w_got_reg  <= w_got_next;
         awa_reg    <= awa_next;
         wd_reg     <= wd_next;
         ws_reg     <= ws_next;
         bresp_reg  <= bresp_next;
         rresp_reg  <= rresp_next;
         rdata_reg  <= rdata_next;
         en_reg     <= en_next;
         frz_reg    <= frz_next;
         aw_rdy_reg <= aw_rdy_next;
         w_rdy_reg  <= w_rdy_next;
         ar_rdy_reg <= ar_rdy_next;
         bv_reg     <= bv_next;
         rv_reg     <= rv_next;
         for (int c = 0; c < N; c++)
            cnt_reg[c] <= cnt_next[c];
      end
   end

   // handshake outputs follow the slave state
   always_comb begin
      s_axi_awready = aw_rdy_reg;
      s_axi_wready  = w_rdy_reg;
      s_axi_arready = ar_rdy_reg;
      s_axi_bvalid  = bv_reg;
      s_axi_rvalid  = rv_reg;
      s_axi_bresp   = bresp_reg;
      s_axi_rresp   = rresp_reg;
      s_axi_rdata   = rdata_reg;
      frozen        = frz_reg;
   end

   // frozen counter holds unless written
   a_frozen_hold : assert property (@(posedge aclk) disable iff (!aresetn)
      frz_reg && !(aw_got_reg && w_got_reg) |=> cnt_reg[0] == $past(cnt_reg[0]))   // RQ9
      else $error("frozen counter changed");
   // unfrozen enabled counter steps by one per event
   a_count_step : assert property (@(posedge aclk) disable iff (!aresetn)
      !frz_reg && en_reg[0] && event_hit[0] && !(aw_got_reg && w_got_reg) && st_reg == pecb_pkg::PECB_IDLE
      |=> cnt_reg[0] == (($past(cnt_reg[0]) + 64'h1) & cnt_mask(0)))                 // RQ17
      else $error("counter step wrong");
   // freeze command sets frozen
   a_freeze_cmd : assert property (@(posedge aclk) disable iff (!aresetn)
      st_reg == pecb_pkg::PECB_IDLE && aw_got_reg && w_got_reg && awa_reg == pecb_pkg::CMD_OFF
      && ws_reg[0] && wd_reg[7:0] == pecb_pkg::CMD_FREEZE && MON_SUPPORTED |=> frz_reg)  // RQ15
      else $error("freeze not applied");
   // unfreeze command clears frozen
   a_unfreeze_cmd : assert property (@(posedge aclk) disable iff (!aresetn)
      st_reg == pecb_pkg::PECB_IDLE && aw_got_reg && w_got_reg && awa_reg == pecb_pkg::CMD_OFF
      && ws_reg[0] && wd_reg[7:0] == pecb_pkg::CMD_UNFREEZE && MON_SUPPORTED |=> !frz_reg) // RQ16
      else $error("unfreeze not applied");
   // bits above width never set
   a_width_mask : assert property (@(posedge aclk) disable iff (!aresetn)
      (cnt_reg[1] & ~cnt_mask(1)) == 64'h0)                                              // RQ12
      else $error("counter bits above width set");
   // full write to counter 0 low word lands, masked to its width
   a_write_land : assert property (@(posedge aclk) disable iff (!aresetn)
      st_reg == pecb_pkg::PECB_IDLE && aw_got_reg && w_got_reg && awa_reg == pecb_pkg::CNT_BASE
      && ws_reg == 4'hf && MON_SUPPORTED
      |=> {32'h0, cnt_reg[0][31:0]} == ({32'h0, $past(wd_reg)} & cnt_mask(0)))             // RQ8
      else $error("counter write lost");
   // unfreeze adds nothing for events before it
   a_resume_clean : assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(frz_reg) && st_reg != pecb_pkg::PECB_IDLE |-> cnt_reg[1] == $past(cnt_reg[1]))  // RQ10
      else $error("resume counted old event");
   // event capability read masks group index without flag
   a_egi_zero : assert property (@(posedge aclk) disable iff (!aresetn)
      st_reg == pecb_pkg::PECB_IDLE && !(aw_got_reg && w_got_reg) && s_axi_arvalid
      && s_axi_araddr == pecb_pkg::CFG_BASE + pecb_pkg::CAP_STRIDE + pecb_pkg::EVCAP_OFF && !OWN_CAPS_FLAGS[1]
      |=> s_axi_rvalid && s_axi_rdata[31:28] == 4'h0)                                    // RQ5
      else $error("group index not zero");
endmodule
`default_nettype wire

// ### inc/pecb_pkg.sv
// Overview of operation
// RQ1 - the per-counter event capability registers exist only while the global per-counter capabilities flag is 1.
// RQ2 - each event capability register describes only its own counter and applies only when that counter's flag is 1.
// RQ3 - with performance monitoring reported unsupported, no event capability or counter register is provided.
// RQ4 - bits 31:28 of each event capability register read back the index of an event group the counter can count.
// RQ5 - the event group index reads as zero when the counter's per-counter capability flag is clear.
// RQ6 - bits 27:0 of each event capability register are a read-only bitmap of supported events in that group.
// RQ7 - each counter counts its configured events with width N taken from the global or per-counter capability.
// RQ8 - after a software write a counter keeps incrementing from the written value.
// RQ9 - a freeze stops every counter and holds its value at the moment of freezing.
// RQ10 - an unfreeze lets a frozen counter resume, adding only events after the unfreeze.
// RQ11 - counter c sits at the counter base plus c times the counter stride, aligned to the stride.
// RQ12 - the count occupies bits N-1:0 and resets to zero, and bits N to 63 read as zero.
// RQ13 - with a counter's per-counter flag set, its width comes from its own capability register.
// RQ14 - an N-bit counter reaches a maximum count of two to the N minus one.
// RQ15 - command code 244 freezes all counters.
// RQ16 - command code 245 unfreezes all counters.
// RQ17 - an enabled, unfrozen counter adds exactly one per event and never changes while frozen except by a write.
package pecb_pkg;
   localparam int          NUM_CNT       = 4;
   localparam int          CNT_IDX_W     = 2;
   localparam int          ADDR_W        = 12;
   localparam logic [7:0]  GLOBAL_WIDTH  = 8'h30;      // global counter width
   localparam logic [ADDR_W-1:0] CFG_BASE    = 12'h000; // configuration offset
   localparam logic [ADDR_W-1:0] CNT_BASE    = 12'h800; // counter offset
   localparam logic [ADDR_W-1:0] CNT_STRIDE  = 12'h010; // counter stride
   localparam logic [ADDR_W-1:0] CAP_STRIDE  = 12'h100;
   localparam logic [ADDR_W-1:0] CNTCAP_OFF  = 12'h080;
   localparam logic [ADDR_W-1:0] EVCAP_OFF   = 12'h084;
   localparam logic [ADDR_W-1:0] CMD_OFF     = 12'h400; // command word, write only
   localparam logic [ADDR_W-1:0] EN_OFF      = 12'h404; // counter enable bits
   localparam logic [ADDR_W-1:0] STAT_OFF    = 12'h408; // frozen status, global flags
   localparam logic [7:0]  CMD_FREEZE    = 8'hf4;      // 244
   localparam logic [7:0]  CMD_UNFREEZE  = 8'hf5;      // 245
   localparam logic [63:0] CNT_RESET     = 64'h0;
   localparam int          GRP_IDX_LSB   = 28;
   localparam int          OWN_CAPS_BIT  = 0;
   localparam int          CW_LSB        = 8;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   typedef enum logic [1:0] {
      PECB_IDLE  = 2'b00,
      PECB_WRESP = 2'b01,
      PECB_RDATA = 2'b10
   } pecb_state_t;
endpackage

// ### bench/pecb_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module pecb_top_test;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, frozen;
   logic [3:0]  event_hit, wstrb;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  bresp, rresp, r;
   logic [31:0] rdata_off;
   logic [1:0]  rresp_off;
   int          bad_count, n_tests;
   // same capability values as the defaults, spelled out so expectations follow from here
   pecb_top #(.MON_SUPPORTED(1'b1), .CAPS_SUPPORTED(1'b1), .OWN_CAPS_FLAGS(4'h5), .CNT_WIDTHS(32'h10_20_18_28),
      .EV_CAPS(128'h3000_00ff_2000_0f0f_1000_00f3_0000_0001)) u_pecb_top (.aclk(aclk), .aresetn(aresetn),
      .event_hit(event_hit), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .frozen(frozen));
   // monitoring reported absent; same handshake timing, so it shadows every transfer of the main copy
   pecb_top #(.MON_SUPPORTED(1'b0), .CAPS_SUPPORTED(1'b1), .OWN_CAPS_FLAGS(4'h5), .CNT_WIDTHS(32'h10_20_18_28),
      .EV_CAPS(128'h3000_00ff_2000_0f0f_1000_00f3_0000_0001)) u_pecb_top_off (.aclk(aclk), .aresetn(aresetn),
      .event_hit(event_hit), .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_bresp(), .s_axi_arvalid(arvalid),
      .s_axi_arready(), .s_axi_araddr(araddr), .s_axi_rvalid(), .s_axi_rready(rready),
      .s_axi_rdata(rdata_off), .s_axi_rresp(rresp_off), .frozen());
   // 125 MHz
   always #4 aclk = ~aclk;
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic hang;
      bad_count++;
      $display("BAD %0t bus wait ran out", $time);
      end_sim();
   endtask
   // ready and valid are flops, so sampling in the low phase shows what the next edge takes
   task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
      int  i;
      bit  da, dw, ta, tw, got;
      da = 0; dw = 0; got = 0;
      @(posedge aclk);
      awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= v; wstrb <= 4'hf; bready <= 1;
      for (i = 0; i < 50 && !(da && dw); i++) begin
         @(negedge aclk); ta = awvalid & awready; tw = wvalid & wready;
         @(posedge aclk);
         if (ta) begin awvalid <= 0; da = 1; end
         if (tw) begin wvalid <= 0; dw = 1; end
      end
      if (!(da && dw)) hang();
      for (i = 0; i < 50 && !got; i++) begin
         @(negedge aclk); got = bvalid; rs = bresp;
         @(posedge aclk);
         if (got) bready <= 0;
      end
      if (!got) hang();
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
      int  i;
      bit  ta, got;
      ta = 0; got = 0;
      @(posedge aclk);
      arvalid <= 1; araddr <= a; rready <= 1;
      for (i = 0; i < 50 && !ta; i++) begin
         @(negedge aclk); ta = arvalid & arready;
         @(posedge aclk);
         if (ta) arvalid <= 0;
      end
      if (!ta) hang();
      for (i = 0; i < 50 && !got; i++) begin
         @(negedge aclk); got = rvalid; v = rdata; rs = rresp;
         @(posedge aclk);
         if (got) rready <= 0;
      end
      if (!got) hang();
   endtask
   // one-cycle pulses with a quiet cycle between
   task automatic pulse(input logic [3:0] m, input int n);
      repeat (n) begin
         @(posedge aclk); event_hit <= m;
         @(posedge aclk); event_hit <= 4'h0;
      end
   endtask
   task automatic t_reset;
      rd(12'h830, d, r); chk(d, 32'h0, "cnt3 low reset");
      rd(12'h834, d, r); chk(d, 32'h0, "cnt3 high reset");
      rd(12'h408, d, r); chk(d, 32'h6, "status at reset");
      rd(12'h404, d, r); chk(d, 32'h0, "enables at reset");
      $display("test reset done");
   endtask
   task automatic t_caps;
      logic [31:0] ev [4];
      int c;
      // counters 1 and 3 have no per-counter flag, so their group index reads zero
      ev[0] = 32'h0000_0001; ev[1] = 32'h0000_00f3; ev[2] = 32'h2000_0f0f; ev[3] = 32'h0000_00ff;
      for (c = 0; c < 4; c++) begin
         rd(12'(c * 256 + 132), d, r);
         chk(d, ev[c], "event caps");
         chk({30'h0, r}, 32'h0, "event caps resp");
      end
      rd(12'h080, d, r); chk({16'h0, d[15:0]}, 32'h2801, "cnt0 own width");
      rd(12'h280, d, r); chk({16'h0, d[15:0]}, 32'h2001, "cnt2 own width");
      $display("test caps done");
   endtask
   task automatic t_count;
      wr(12'h404, 32'h3, r); rd(12'h404, d, r); chk(d, 32'h3, "enable readback");
      wr(12'h800, 32'hffff_fffd, r); wr(12'h804, 32'h0000_00ff, r);
      pulse(4'h1, 2);
      rd(12'h800, d, r); chk(d, 32'hffff_ffff, "cnt0 low after events");
      rd(12'h804, d, r); chk(d, 32'h0000_00ff, "cnt0 high at max");
      wr(12'h804, 32'hffff_ffff, r); rd(12'h804, d, r);
      chk(d, 32'h0000_00ff, "cnt0 bits above 40 zero");
      wr(12'h810, 32'h10, r); wr(12'h814, 32'hffff_ffff, r);
      rd(12'h814, d, r); chk(d, 32'h0000_ffff, "cnt1 global width 48");
      pulse(4'h2, 1);
      rd(12'h810, d, r); chk(d, 32'h11, "cnt1 one event");
      rd(12'h820, d, r); chk(d, 32'h0, "cnt2 disabled stays");
      $display("test count done");
   endtask
   task automatic t_freeze;
      wr(12'h400, 32'hf4, r); chk({31'h0, frozen}, 32'h1, "frozen after 244");
      chk({30'h0, r}, 32'h0, "freeze write okay");
      rd(12'h408, d, r); chk(d, 32'h7, "status frozen");
      pulse(4'h2, 3);
      rd(12'h810, d, r); chk(d, 32'h11, "cnt1 held while frozen");
      wr(12'h810, 32'h20, r); rd(12'h810, d, r); chk(d, 32'h20, "write while frozen");
      wr(12'h400, 32'hf5, r); chk({31'h0, frozen}, 32'h0, "running after 245");
      pulse(4'h2, 2);
      rd(12'h810, d, r); chk(d, 32'h22, "cnt1 resumes");
      $display("test freeze done");
   endtask
   task automatic t_bad;
      rd(12'h7f0, d, r); chk({30'h0, r}, 32'h2, "unmapped read");
      chk(d, 32'h0, "unmapped read data");
      rd(12'h400, d, r); chk({30'h0, r}, 32'h2, "command word read");
      wr(12'h7f0, 32'h1, r); chk({30'h0, r}, 32'h2, "unmapped write");
      $display("test errors done");
   endtask
   // the shadow copy keeps its last read word until the next read is taken
   task automatic t_absent;
      rd(12'h084, d, r); chk({30'h0, rresp_off}, 32'h2, "caps absent resp");
      chk(rdata_off, 32'h0, "caps absent data");
      rd(12'h810, d, r); chk({30'h0, rresp_off}, 32'h2, "counter absent resp");
      chk(rdata_off, 32'h0, "counter absent data");
      rd(12'h408, d, r); chk(rdata_off, 32'h4, "status without monitoring");
      $display("test absent done");
   endtask
   initial begin
      aclk = 0; aresetn = 0; event_hit = 4'h0; awvalid = 0; awaddr = 12'h000; wvalid = 0;
      wdata = 32'h0; wstrb = 4'h0; bready = 0; arvalid = 0; araddr = 12'h000; rready = 0;
      bad_count = 0; n_tests = 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      t_reset();
      t_caps();
      t_count();
      t_freeze();
      t_bad();
      t_absent();
      end_sim();
   end
endmodule
`default_nettype wire
